// ==== verilog/dai_params.svh ====
// Constants for the data address index and status block.
`ifndef DAI_PARAMS_SVH
`define DAI_PARAMS_SVH

// Data memory address layout: bank, row, column.
`define DAI_BANK_W 4
`define DAI_ROW_W 3
`define DAI_COL_W 4
`define DAI_ADDR_W 11
`define DAI_NIB_W 4
`define DAI_SW_W 5

// System register addresses, bank 0, row 7.
`define DAI_OFS_RPH 11'h07D
`define DAI_OFS_RPL 11'h07E
`define DAI_OFS_PSW 11'h07F

// Field positions in the pointer and flag registers.
`define DAI_RPL_RP_MSB 3
`define DAI_RPL_RP_LSB 1
`define DAI_RPL_BCD_BIT 0
`define DAI_PSW_CMP_BIT 3
`define DAI_PSW_CY_BIT 2
`define DAI_PSW_Z_BIT 1
`define DAI_PSW_IXE_BIT 0

// Status word bit positions: decimal flag on top, then the flag nibble.
`define DAI_SW_BCD_BIT 4
`define DAI_SW_CMP_BIT 3
`define DAI_SW_CY_BIT 2
`define DAI_SW_Z_BIT 1
`define DAI_SW_IXE_BIT 0

// Reset and fixed values.
`define DAI_RP_RST 3'h0
`define DAI_FLAG_RST 1'b0
`define DAI_SW_RST 5'h00
`define DAI_RPH_VALUE 4'h0
`define DAI_GR_BANK 4'h0
`define DAI_NIB_ZERO 4'h0
`define DAI_ADDR_ZERO 11'h000

`endif

// ==== verilog/dai_pkg.sv ====
// Types shared by the data address index and status block.
`include "dai_params.svh"

package dai_pkg;

  typedef logic [`DAI_NIB_W-1:0] dai_nib_t;
  typedef logic [`DAI_SW_W-1:0] dai_sw_t;
  typedef logic [`DAI_ROW_W-1:0] dai_row_t;

  typedef struct packed {
    logic [`DAI_BANK_W-1:0] bank;
    logic [`DAI_ROW_W-1:0] row;
    logic [`DAI_COL_W-1:0] col;
  } dai_addr_s;

  typedef enum logic {
    DAI_OP_DIRECT,
    DAI_OP_GR_INDIRECT
  } dai_op_e;

endpackage

// ==== verilog/dai_addr_if.sv ====
// Address path between the register core and the index modifier.
`timescale 1ns/10ps
`default_nettype none

interface dai_addr_if;
  import dai_pkg::*;

  dai_addr_s mem_addr;
  dai_addr_s index_register;
  logic index_enable_flag;
  dai_nib_t ind_col;
  dai_addr_s real_direct;
  dai_addr_s real_indirect;

  modport core (
    output mem_addr,
    output index_register,
    output index_enable_flag,
    output ind_col,
    input real_direct,
    input real_indirect
  );

  modport modifier (
    input mem_addr,
    input index_register,
    input index_enable_flag,
    input ind_col,
    output real_direct,
    output real_indirect
  );
endinterface

`default_nettype wire

// ==== verilog/dai_index_mod.sv ====
// Index modification of direct and general register indirect addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dai_params.svh"

module dai_index_mod
  import dai_pkg::*;
(
  // Address path
  dai_addr_if.modifier ap
);

  logic [`DAI_BANK_W-1:0] ix_bank;
  logic [`DAI_ROW_W-1:0] ix_row;

  always_comb begin
    ix_bank = ap.index_enable_flag ? ap.index_register.bank : '0;
    ix_row = ap.index_enable_flag ? ap.index_register.row : '0;
  end

  // Whole direct address is ORed with the index register when enabled.
  always_comb begin
    if (ap.index_enable_flag) begin
      ap.real_direct = dai_addr_s'(ap.mem_addr | ap.index_register);
    end else begin
      ap.real_direct = ap.mem_addr;
    end
  end

  // Indirect bank and row start from the operand and take the index when enabled; the
  // column is the general register contents and is never modified.
  always_comb begin
    ap.real_indirect.bank = ap.mem_addr.bank | ix_bank;
    ap.real_indirect.row = ap.mem_addr.row | ix_row;
    ap.real_indirect.col = ap.ind_col;
  end

endmodule

`default_nettype wire

// ==== verilog/dai_core_regs.sv ====
// Index modification, general register pointer and status word core.
`timescale 1ns/10ps
`default_nettype none
`include "dai_params.svh"

module dai_core_regs
  import dai_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,

  // Instruction request from the execution core
  input wire logic req_valid,
  input wire dai_op_e req_op,
  input wire dai_addr_s req_mem_addr,
  input wire dai_nib_t req_r_col,
  input wire dai_nib_t req_r_data,
  input wire logic req_wr,
  input wire dai_nib_t req_wdata,

  // Index register contents held by the core
  input wire dai_addr_s index_register,

  // Arithmetic result flags
  input wire logic alu_flag_we,
  input wire logic alu_carry,
  input wire logic alu_result_zero,

  // Interrupt entry and return
  input wire logic int_take,
  input wire logic int_return,

  // Resolved addresses and system register read data
  output logic rsp_valid_ff,
  output dai_addr_s rsp_direct_addr_ff,
  output dai_addr_s rsp_indirect_addr_ff,
  output dai_addr_s rsp_gr_addr_ff,
  output logic rsp_sysreg_hit_ff,
  output dai_nib_t rsp_rdata_ff,

  // Flags and pointer state
  output logic index_enable_flag_ff,
  output logic compare_only_flag_ff,
  output logic carry_flag_ff,
  output logic zero_flag_ff,
  output logic bcd_mode_flag_ff,
  output dai_row_t general_reg_row_pointer_ff,
  output dai_sw_t stack_status_word_ff
);

  dai_addr_if ap ();

  dai_addr_s acc_addr;
  dai_nib_t nxt_rdata;
  logic nxt_hit;
  logic wr_lower;
  logic wr_flags;
  dai_nib_t rpl_value;
  dai_nib_t psw_value;
  dai_sw_t status_word;
  dai_addr_s gr_addr;
  logic nxt_zero;
  logic nxt_carry;

  // Drive the shared address path; the modifier does the OR work.
  assign ap.mem_addr = req_mem_addr;
  assign ap.index_register = index_register;
  assign ap.index_enable_flag = index_enable_flag_ff;
  assign ap.ind_col = req_r_data;

  dai_index_mod u_index_mod (
    .ap (ap.modifier)
  );

  // The system registers are decoded on the real address, so with the
  // index enabled an access to the flag nibble lands elsewhere unless
  // the index sets no bit that the address lacks. Software clears the enable first when it wants
  // the flag nibble itself.
  always_comb begin
    if (req_op == DAI_OP_GR_INDIRECT && req_wr) begin
      acc_addr = ap.real_indirect;
    end else begin
      acc_addr = ap.real_direct;
    end
  end

  // Write strobes per system register. The upper pointer nibble gets no
  // strobe at all, since its four bits are wired to zero.
  always_comb begin
    wr_lower = 1'b0;
    wr_flags = 1'b0;
    if (req_valid && req_wr) begin
      wr_lower = (acc_addr == `DAI_OFS_RPL);
      wr_flags = (acc_addr == `DAI_OFS_PSW);
    end
  end

  // Pointer nibble packs the three row bits above the decimal bit.
  always_comb begin
    rpl_value = {general_reg_row_pointer_ff, bcd_mode_flag_ff};
  end

  // Flag nibble as software reads it.
  always_comb begin
    psw_value = '0;
    psw_value[`DAI_PSW_CMP_BIT] = compare_only_flag_ff;
    psw_value[`DAI_PSW_CY_BIT] = carry_flag_ff;
    psw_value[`DAI_PSW_Z_BIT] = zero_flag_ff;
    psw_value[`DAI_PSW_IXE_BIT] = index_enable_flag_ff;
  end

  // Five-bit word for the interrupt save: decimal flag above the nibble.
  always_comb begin
    status_word = '0;
    status_word[`DAI_SW_BCD_BIT] = bcd_mode_flag_ff;
    status_word[`DAI_SW_CMP_BIT] = compare_only_flag_ff;
    status_word[`DAI_SW_CY_BIT] = carry_flag_ff;
    status_word[`DAI_SW_Z_BIT] = zero_flag_ff;
    status_word[`DAI_SW_IXE_BIT] = index_enable_flag_ff;
  end

  // Read decode returns the value held before this instruction.
  always_comb begin
    nxt_hit = 1'b1;
    unique case (acc_addr)
      `DAI_OFS_RPH: nxt_rdata = `DAI_RPH_VALUE;
      `DAI_OFS_RPL: nxt_rdata = rpl_value;
      `DAI_OFS_PSW: nxt_rdata = psw_value;
      default: begin
        nxt_rdata = `DAI_NIB_ZERO;
        nxt_hit = 1'b0;
      end
    endcase
  end

  // The general register is a fixed bank 0 row picked by the pointer;
  // with only three pointer bits it can never leave rows 0 to 7.
  always_comb begin
    gr_addr.bank = `DAI_GR_BANK;
    gr_addr.row = general_reg_row_pointer_ff;
    gr_addr.col = req_r_col;
  end

  // Zero flag: a compare-only operation may clear but never set it.
  always_comb begin
    if (!alu_result_zero) begin
      nxt_zero = 1'b0;
    end else if (compare_only_flag_ff) begin
      nxt_zero = zero_flag_ff;
    end else begin
      nxt_zero = 1'b1;
    end
  end

  // Carry takes the arithmetic result whatever the compare flag says;
  // only the zero flag is shielded by a compare-only operation.
  always_comb begin
    nxt_carry = alu_carry;
  end

  // Response strobe: one cycle per taken request.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= req_valid;
    end
  end

  // Resolved addresses stand until the next taken request.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsp_direct_addr_ff <= `DAI_ADDR_ZERO;
      rsp_indirect_addr_ff <= `DAI_ADDR_ZERO;
      rsp_gr_addr_ff <= `DAI_ADDR_ZERO;
    end else if (req_valid) begin
      rsp_direct_addr_ff <= ap.real_direct;
      rsp_indirect_addr_ff <= ap.real_indirect;
      rsp_gr_addr_ff <= gr_addr;
    end
  end

  // Read data is the value held before any same-cycle write lands.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsp_sysreg_hit_ff <= 1'b0;
      rsp_rdata_ff <= `DAI_NIB_ZERO;
    end else if (req_valid) begin
      rsp_sysreg_hit_ff <= nxt_hit;
      rsp_rdata_ff <= nxt_rdata;
    end
  end

  // Row pointer. Writes to the upper nibble are dropped because those
  // four bits are wired to zero.
  // A return from interrupt keeps the pointer; it is not in the saved word.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      general_reg_row_pointer_ff <= `DAI_RP_RST;
    end else if (int_return) begin
      general_reg_row_pointer_ff <= general_reg_row_pointer_ff;
    end else if (wr_lower) begin
      general_reg_row_pointer_ff <=
        req_wdata[`DAI_RPL_RP_MSB:`DAI_RPL_RP_LSB];
    end
  end

  // Decimal mode flag. It shares its nibble with the row pointer, so one
  // write to that nibble sets both.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bcd_mode_flag_ff <= `DAI_FLAG_RST;
    end else if (int_return) begin
      bcd_mode_flag_ff <= stack_status_word_ff[`DAI_SW_BCD_BIT];
    end else if (wr_lower) begin
      bcd_mode_flag_ff <= req_wdata[`DAI_RPL_BCD_BIT];
    end
  end

  // Index enable flag. A new value steers only requests from the next
  // cycle on; the request that writes it was decoded with the old one.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      index_enable_flag_ff <= `DAI_FLAG_RST;
    end else if (int_return) begin
      index_enable_flag_ff <= stack_status_word_ff[`DAI_SW_IXE_BIT];
    end else if (wr_flags) begin
      index_enable_flag_ff <= req_wdata[`DAI_PSW_IXE_BIT];
    end
  end

  // Compare-only flag. It changes only by a write or a return from
  // interrupt; arithmetic results never touch it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      compare_only_flag_ff <= `DAI_FLAG_RST;
    end else if (int_return) begin
      compare_only_flag_ff <= stack_status_word_ff[`DAI_SW_CMP_BIT];
    end else if (wr_flags) begin
      compare_only_flag_ff <= req_wdata[`DAI_PSW_CMP_BIT];
    end
  end

  // Carry flag. A result from the arithmetic unit beats a software write
  // in the same cycle so that no hardware event is lost.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      carry_flag_ff <= `DAI_FLAG_RST;
    end else if (int_return) begin
      carry_flag_ff <= stack_status_word_ff[`DAI_SW_CY_BIT];
    end else if (alu_flag_we) begin
      carry_flag_ff <= nxt_carry;
    end else if (wr_flags) begin
      carry_flag_ff <= req_wdata[`DAI_PSW_CY_BIT];
    end
  end

  // Zero flag, with the same priority as the carry flag.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      zero_flag_ff <= `DAI_FLAG_RST;
    end else if (int_return) begin
      zero_flag_ff <= stack_status_word_ff[`DAI_SW_Z_BIT];
    end else if (alu_flag_we) begin
      zero_flag_ff <= nxt_zero;
    end else if (wr_flags) begin
      zero_flag_ff <= req_wdata[`DAI_PSW_Z_BIT];
    end
  end

  // Single-level save of the status word on interrupt entry. The value
  // captured is the one standing before any same-cycle update.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stack_status_word_ff <= `DAI_SW_RST;
    end else if (int_take) begin
      stack_status_word_ff <= status_word;
    end
  end

endmodule

`default_nettype wire

// ==== tb/dai_core_regs_sva.sv ====
// Assertion checker for the address index and status core.
`timescale 1ns/10ps
`default_nettype none
`include "dai_params.svh"

module dai_core_regs_sva
  import dai_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Requests and side inputs
  input wire logic req_valid,
  input wire dai_op_e req_op,
  input wire dai_addr_s req_mem_addr,
  input wire dai_nib_t req_r_col,
  input wire dai_nib_t req_r_data,
  input wire dai_addr_s index_register,
  input wire logic alu_flag_we,
  input wire logic alu_carry,
  input wire logic int_take,
  input wire logic int_return,
  // Responses and state
  input wire logic rsp_valid_ff,
  input wire dai_addr_s rsp_direct_addr_ff,
  input wire dai_addr_s rsp_indirect_addr_ff,
  input wire dai_addr_s rsp_gr_addr_ff,
  input wire logic rsp_sysreg_hit_ff,
  input wire dai_nib_t rsp_rdata_ff,
  input wire logic index_enable_flag_ff,
  input wire logic compare_only_flag_ff,
  input wire logic carry_flag_ff,
  input wire logic zero_flag_ff,
  input wire logic bcd_mode_flag_ff,
  input wire dai_row_t general_reg_row_pointer_ff,
  input wire dai_sw_t stack_status_word_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  dai_sw_t cur_sw;
  assign cur_sw = {bcd_mode_flag_ff, compare_only_flag_ff, carry_flag_ff,
    zero_flag_ff, index_enable_flag_ff};

  a_rsp_pulse: assert property (req_valid |=> rsp_valid_ff)
    else $error("response missing");
  a_rsp_single: assert property (!req_valid |=> !rsp_valid_ff)
    else $error("response without request");
  a_direct_index: assert property (req_valid && index_enable_flag_ff |=>
    rsp_direct_addr_ff == ($past(req_mem_addr) | $past(index_register)))
    else $error("direct address not index modified");
  a_direct_plain: assert property (req_valid && !index_enable_flag_ff |=>
    rsp_direct_addr_ff == $past(req_mem_addr))
    else $error("direct address modified while disabled");
  a_indirect_index: assert property (req_valid && index_enable_flag_ff |=>
    rsp_indirect_addr_ff == {$past(req_mem_addr[10:4] | index_register[10:4]),
    $past(req_r_data)})
    else $error("indirect address wrong");
  a_gr_row: assert property (req_valid |=> rsp_gr_addr_ff ==
    {4'h0, $past(general_reg_row_pointer_ff), $past(req_r_col)})
    else $error("general register address wrong");
  a_upper_zero: assert property (req_valid && !index_enable_flag_ff &&
    req_op == DAI_OP_DIRECT && req_mem_addr == `DAI_OFS_RPH |=>
    rsp_sysreg_hit_ff && rsp_rdata_ff == `DAI_RPH_VALUE)
    else $error("upper pointer nibble not zero");
  a_reset_clear: assert property ($fell(srst) |-> cur_sw == `DAI_SW_RST &&
    general_reg_row_pointer_ff == `DAI_RP_RST && stack_status_word_ff == 5'h00)
    else $error("state not cleared by reset");
  a_int_save: assert property (int_take && !int_return |=>
    stack_status_word_ff == $past(cur_sw))
    else $error("status word not saved");
  a_carry_alu: assert property (alu_flag_we && !int_return |=>
    carry_flag_ff == $past(alu_carry))
    else $error("carry not updated");
  a_flags_hold: assert property (!req_valid && !alu_flag_we && !int_return
    |=> $stable(cur_sw) && $stable(general_reg_row_pointer_ff))
    else $error("flags changed without cause");

  c_int: cover property (int_take);
  c_index: cover property (req_valid && index_enable_flag_ff);
  c_cmp_alu: cover property (alu_flag_we && compare_only_flag_ff);
endmodule

`default_nettype wire

// ==== tb/dai_core_regs_tb_top.sv ====
// Self-checking bench for the address index and status core.
`timescale 1ns/10ps
`default_nettype none
`include "dai_params.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module dai_core_regs_tb_top
  import dai_pkg::*;
;
  logic ref_clk = 0, srst = 1, req_valid = 0, req_wr = 0, alu_flag_we = 0;
  logic alu_carry = 0, alu_result_zero = 0, int_take = 0, int_return = 0;
  dai_op_e req_op = DAI_OP_DIRECT;
  dai_addr_s req_mem_addr = 11'h000, index_register = 11'h000;
  dai_nib_t req_r_col = 4'h0, req_r_data = 4'h0, req_wdata = 4'h0;
  logic rsp_valid_ff, rsp_sysreg_hit_ff, index_enable_flag_ff;
  logic compare_only_flag_ff, carry_flag_ff, zero_flag_ff, bcd_mode_flag_ff;
  dai_addr_s rsp_direct_addr_ff, rsp_indirect_addr_ff, rsp_gr_addr_ff;
  dai_nib_t rsp_rdata_ff;
  dai_row_t general_reg_row_pointer_ff;
  dai_sw_t stack_status_word_ff;
  int fail_count = 0, cmp_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  dai_core_regs i_dai_core_regs (.*);

  // One request, checked one cycle later against the pre-write value.
  task automatic acc(input logic [10:0] a, input logic w, input dai_nib_t d,
    input dai_nib_t exp);
    @(posedge ref_clk);
    req_mem_addr <= a;
    req_wr <= w;
    req_wdata <= d;
    req_r_col <= d;
    req_r_data <= ~d;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_wr <= 1'b0;
    #1;
    `CHK(rsp_rdata_ff, exp)
    `CHK(rsp_valid_ff, 1'b1)
  endtask

  // Kind 0 takes an interrupt, 1 returns, 2 updates flags from the ALU.
  task automatic pulse(input int k);
    @(posedge ref_clk);
    int_take <= (k == 0);
    int_return <= (k == 1);
    alu_flag_we <= (k == 2);
    @(posedge ref_clk);
    int_take <= 1'b0;
    int_return <= 1'b0;
    alu_flag_we <= 1'b0;
    #1;
  endtask

  task automatic report_and_stop;
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    report_and_stop;
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    acc(`DAI_OFS_RPH, 0, 4'h0, 4'h0);
    `CHK(rsp_sysreg_hit_ff, 1'b1)
    acc(`DAI_OFS_RPL, 0, 4'h0, 4'h0);
    acc(`DAI_OFS_PSW, 0, 4'h0, 4'h0);
    `CHK(stack_status_word_ff, `DAI_SW_RST)
    $display("test reset done");
    for (int v = 0; v < 16; v++) begin
      acc(`DAI_OFS_RPL, 1, v[3:0], v == 0 ? 4'h0 : 4'(v - 1));
      `CHK(general_reg_row_pointer_ff, v[3:1])
      `CHK(bcd_mode_flag_ff, v[0])
    end
    `CHK(general_reg_row_pointer_ff, 3'h7)
    acc(`DAI_OFS_RPH, 1, 4'hF, 4'h0);
    acc(`DAI_OFS_RPH, 0, 4'h9, 4'h0);
    `CHK(rsp_gr_addr_ff, 11'h079)
    $display("test pointer done");
    for (int i = 0; i < 4; i++) begin
      acc(`DAI_OFS_PSW, 1, 4'(1 << i), i == 0 ? 4'h0 : 4'(1 << (i - 1)));
      `CHK({compare_only_flag_ff, carry_flag_ff, zero_flag_ff,
        index_enable_flag_ff}, 4'(1 << i))
    end
    acc(`DAI_OFS_PSW, 1, 4'h1, 4'h8);
    @(posedge ref_clk);
    index_register <= 11'h012;
    acc(11'h061, 0, 4'h8, 4'h0);
    `CHK(rsp_direct_addr_ff, 11'h073)
    `CHK(rsp_indirect_addr_ff, 11'h077)
    `CHK(rsp_sysreg_hit_ff, 1'b0)
    @(posedge ref_clk);
    index_register <= 11'h080;
    acc(`DAI_OFS_PSW, 1, 4'h0, 4'h0);
    `CHK(index_enable_flag_ff, 1'b1)
    `CHK(rsp_direct_addr_ff, 11'h0FF)
    @(posedge ref_clk);
    index_register <= 11'h000;
    acc(`DAI_OFS_PSW, 1, 4'h0, 4'h1);
    `CHK(index_enable_flag_ff, 1'b0)
    @(posedge ref_clk);
    index_register <= 11'h012;
    acc(11'h061, 0, 4'h0, 4'h0);
    `CHK(rsp_direct_addr_ff, 11'h061)
    $display("test index done");
    acc(`DAI_OFS_PSW, 1, 4'hC, 4'h0);
    pulse(0);
    `CHK(stack_status_word_ff, 5'h1C)
    @(posedge ref_clk);
    alu_result_zero <= 1'b1;
    pulse(2);
    `CHK({carry_flag_ff, zero_flag_ff}, 2'h0)
    acc(`DAI_OFS_PSW, 1, 4'h0, 4'h8);
    @(posedge ref_clk);
    alu_carry <= 1'b1;
    pulse(2);
    `CHK(zero_flag_ff, 1'b1)
    `CHK(carry_flag_ff, 1'b1)
    pulse(1);
    `CHK({bcd_mode_flag_ff, compare_only_flag_ff, carry_flag_ff,
      zero_flag_ff, index_enable_flag_ff}, 5'h1C)
    `CHK(general_reg_row_pointer_ff, 3'h7)
    $display("test status done");
    @(posedge ref_clk);
    req_op <= DAI_OP_GR_INDIRECT;
    acc(11'h070, 1, 4'h1, 4'hF);
    `CHK(rsp_indirect_addr_ff, 11'h07E)
    `CHK(rsp_direct_addr_ff, 11'h070)
    `CHK(general_reg_row_pointer_ff, 3'h0)
    @(posedge ref_clk);
    req_op <= DAI_OP_DIRECT;
    acc(`DAI_OFS_RPL, 1, 4'hE, 4'h1);
    $display("test indirect done");
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    `CHK(general_reg_row_pointer_ff, `DAI_RP_RST)
    `CHK({bcd_mode_flag_ff, compare_only_flag_ff, carry_flag_ff,
      zero_flag_ff, index_enable_flag_ff}, `DAI_SW_RST)
    `CHK(stack_status_word_ff, `DAI_SW_RST)
    acc(`DAI_OFS_PSW, 0, 4'h0, 4'h0);
    $display("test mid-run reset done");
    report_and_stop;
  end
endmodule

bind dai_core_regs dai_core_regs_sva i_dai_core_regs_sva (.*);

`default_nettype wire
